// [logic/effp_pkg.sv]
/*
  effp_pkg: shared constants and carrier structs for the flop pair.
  assumes: all users sit on one 125 MHz clock domain.
*/
package effp_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned SYNC_STAGES   = 3;

  // ==========================================================
  // reset values
  localparam logic DFF_RST_VAL = 1'b0;
  localparam logic MSF_RST_VAL = 1'b0;
  // synchroniser idle levels, d_clk in the msb down to m_clr_n in the lsb:
  // clocks and steering low, direct lines high so reset forces nothing
  localparam logic [8:0] SYNC_IDLE = 9'h063;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic set_n;
    logic clr_n;
  } effp_direct_s;

  typedef struct packed {
    logic q;
    logic q_n;
  } effp_out_s;
endpackage

// [logic/effp_sync.sv]
/*
  effp_sync: three-stage input synchroniser.
  assumes: input is asynchronous to clock; output is the agreed level.
*/
`timescale 1ns/1ps
module effp_sync
  import effp_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
)
(
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic din,
  output logic      dout
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic agree;

  // stage one is read only by stage two
  assign agree = (s2_q == s3_q);

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      dout <= RST_VAL;
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (agree)
      begin
        dout <= s3_q;
      end
    end
  end
endmodule

// [logic/effp_edge.sv]
/*
  effp_edge: rise and fall pulse detector on a synchronised level.
  assumes: input already on the clock domain.
*/
`timescale 1ns/1ps
module effp_edge
  import effp_pkg::*;
(
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic lvl,
  output logic      rise,
  output logic      fall
);
  logic prev_q;

  assign rise = lvl & ~prev_q;
  assign fall = ~lvl & prev_q;

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prev_q <= 1'b0;
    end
    else
    begin
      prev_q <= lvl;
    end
  end
endmodule

// [logic/effp_top.sv]
/*
  effp_top: edge-triggered data flop with lockout and a master-slave
  steered flop, both with active-low direct set and clear.
  assumes: all pulse inputs come from outside the clock domain and are
  far slower than the 8 ns sampling clock; pulses shorter than about
  two clocks may be missed.
*/
`timescale 1ns/1ps

module effp_top
  import effp_pkg::*;
(
  input  wire logic   clock,
  input  wire logic   sys_rst,
  input  wire logic   d_clk,
  input  wire logic   d_data,
  input  wire logic   d_set_n,
  input  wire logic   d_clr_n,
  output effp_out_s   d_out,
  input  wire logic   m_clk,
  input  wire logic   m_jset,
  input  wire logic   m_kclr,
  input  wire logic   m_set_n,
  input  wire logic   m_clr_n,
  output effp_out_s   m_out
);
  // ==========================================================
  // input synchronisation
  logic dclk_s;
  logic ddat_s;
  logic dset_n_s;
  logic dclr_n_s;
  logic mclk_s;
  logic mj_s;
  logic mk_s;
  logic mset_n_s;
  logic mclr_n_s;
  logic [8:0] raw;
  logic [8:0] syn;

  // direct lines idle high; idle value avoids a spurious force at reset
  assign raw = {d_clk, d_data, d_set_n, d_clr_n, m_clk, m_jset, m_kclr, m_set_n, m_clr_n};
  assign {dclk_s, ddat_s, dset_n_s, dclr_n_s, mclk_s, mj_s, mk_s, mset_n_s, mclr_n_s} = syn;

  genvar gi;
  generate
    for (gi = 0; gi < 9; gi++)
    begin : g_sync
      effp_sync #(
        .RST_VAL (SYNC_IDLE[gi])
      ) u_sync (
        .clock   (clock),
        .sys_rst (sys_rst),
        .din     (raw[gi]),
        .dout    (syn[gi])
      );
    end
  endgenerate

  // ==========================================================
  // clock edge detection
  logic d_rise;
  logic m_rise;
  logic m_fall;

  effp_edge u_dedge (
    .clock   (clock),
    .sys_rst (sys_rst),
    .lvl     (dclk_s),
    .rise    (d_rise),
    .fall    ()
  );

  effp_edge u_medge (
    .clock   (clock),
    .sys_rst (sys_rst),
    .lvl     (mclk_s),
    .rise    (m_rise),
    .fall    (m_fall)
  );

  // ==========================================================
  // data flop
  logic d_q;
  logic d_q_d;
  logic d_steer_set;
  logic d_steer_clr;
  logic d_force_set;
  logic d_force_clr;
  logic d_free;

  // steering from one line and its inverse cannot both be active
  assign d_steer_set = ddat_s;
  assign d_steer_clr = ~ddat_s;
  assign d_force_clr = ~dclr_n_s;
  assign d_force_set = ~dset_n_s & dclr_n_s;
  assign d_free      = dset_n_s & dclr_n_s;

  // sampling happens only on the rise pulse, so later data changes while
  // the clock stays high are locked out until the next rise
  assign d_q_d = d_force_clr ? 1'b0 :
                 d_force_set ? 1'b1 :
                 (d_rise & d_steer_set) ? 1'b1 :
                 (d_rise & d_steer_clr) ? 1'b0 :
                 d_q;

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      d_q   <= DFF_RST_VAL;
      d_out <= '{q: DFF_RST_VAL, q_n: ~DFF_RST_VAL};
    end
    else
    begin
      d_q   <= d_q_d;
      d_out <= '{q: d_q_d, q_n: ~d_q_d};
    end
  end

  // ==========================================================
  // master-slave flop
  logic ms_mst_q;
  logic ms_mst_d;
  logic ms_slv_q;
  logic ms_slv_d;
  logic ms_force_set;
  logic ms_force_clr;
  logic ms_clk_hi;
  logic ms_jk_next;
  logic ms_free;

  assign ms_force_clr = ~mclr_n_s;
  assign ms_force_set = ~mset_n_s & mclr_n_s;
  assign ms_clk_hi    = mclk_s;
  assign ms_free      = mset_n_s & mclr_n_s;

  // next state from steering against the current slave state
  assign ms_jk_next = (mj_s & mk_s) ? ~ms_slv_q :
                      mj_s          ? 1'b1 :
                      mk_s          ? 1'b0 :
                      ms_slv_q;

  // master loads on the rise and follows steering while clock is high
  assign ms_mst_d = ms_force_clr ? 1'b0 :
                    ms_force_set ? 1'b1 :
                    (m_rise | (ms_clk_hi & ~m_fall)) ? ms_jk_next :
                    ms_mst_q;

  // apart from a direct force, slave only moves at the fall; blocked while the clock is high
  assign ms_slv_d = ms_force_clr ? 1'b0 :
                    ms_force_set ? 1'b1 :
                    m_fall ? ms_mst_q :
                    ms_slv_q;

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ms_mst_q <= MSF_RST_VAL;
      ms_slv_q <= MSF_RST_VAL;
      m_out    <= '{q: MSF_RST_VAL, q_n: ~MSF_RST_VAL};
    end
    else
    begin
      ms_mst_q <= ms_mst_d;
      ms_slv_q <= ms_slv_d;
      m_out    <= '{q: ms_slv_d, q_n: ~ms_slv_d};
    end
  end

  // ==========================================================
  // check helpers
  logic       d_seen_q;
  logic [2:0] d_hi_cnt_q;
  logic [2:0] d_hi_cnt_d;

  // counts clean high cycles since a rise; a direct force clears it until the
  // next rise so the lockout check never blames the flop for a legal override
  assign d_hi_cnt_d = (!dclk_s || !d_free) ? 3'h0 :
                      d_rise ? 3'h1 :
                      (d_hi_cnt_q == 3'h0 || d_hi_cnt_q == 3'h7) ? d_hi_cnt_q :
                      d_hi_cnt_q + 3'h1;

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      d_seen_q   <= DFF_RST_VAL;
      d_hi_cnt_q <= 3'h0;
    end
    else
    begin
      d_seen_q   <= d_rise ? ddat_s : d_seen_q;
      d_hi_cnt_q <= d_hi_cnt_d;
    end
  end

  // ==========================================================
  // checks
  a_dff_capture: assert property (
    @(posedge clock) disable iff (sys_rst)
    (d_rise && d_free) |=> (d_q == $past(ddat_s)))
    else $error("data flop missed its sample at clock rise");

  a_dff_lockout: assert property (
    @(posedge clock) disable iff (sys_rst)
    (!d_rise && d_free) |=> $stable(d_q))
    else $error("data flop changed without a clock rise");

  a_dff_locked_hi: assert property (
    @(posedge clock) disable iff (sys_rst)
    (d_hi_cnt_q != 3'h0 && d_free) |-> (d_q == d_seen_q))
    else $error("data flop left the value taken at the rise");

  a_dff_steer: assert property (
    @(posedge clock) disable iff (sys_rst)
    (d_rise && d_free) |-> (d_q_d == d_steer_set) && (d_steer_set != d_steer_clr))
    else $error("data flop steering not one line and its inverse");

  a_dff_take_zero: assert property (
    @(posedge clock) disable iff (sys_rst)
    (d_rise && !ddat_s && d_free) |=> !d_q)
    else $error("data flop clear steering ignored");

  a_dff_out_hold: assert property (
    @(posedge clock) disable iff (sys_rst)
    (dclk_s && !d_rise && d_free) |=> $stable(d_out))
    else $error("data flop outputs moved while clock high");

  a_dff_out_track: assert property (
    @(posedge clock) disable iff (sys_rst)
    (d_out.q == d_q) && (d_out.q_n == !d_q))
    else $error("data flop outputs differ from state");

  a_dir_clear: assert property (
    @(posedge clock) disable iff (sys_rst)
    (!dclr_n_s || !mclr_n_s) |=> ($past(dclr_n_s) || !d_q) && ($past(mclr_n_s) || !ms_slv_q))
    else $error("direct clear did not win");

  a_dir_set: assert property (
    @(posedge clock) disable iff (sys_rst)
    (!dset_n_s && dclr_n_s) |=> d_q)
    else $error("data flop direct set ignored");

  a_ms_dir_set: assert property (
    @(posedge clock) disable iff (sys_rst)
    (!mset_n_s && mclr_n_s) |=> (ms_slv_q && m_out.q))
    else $error("master-slave direct set ignored");

  a_ms_dir_clear: assert property (
    @(posedge clock) disable iff (sys_rst)
    !mclr_n_s |=> (!ms_mst_q && !ms_slv_q && !m_out.q))
    else $error("master-slave direct clear ignored");

  a_ms_follow_high: assert property (
    @(posedge clock) disable iff (sys_rst)
    (ms_clk_hi && ms_free) |=> (ms_mst_q == $past(ms_jk_next)))
    else $error("master did not follow steering while clock high");

  a_ms_hold_high: assert property (
    @(posedge clock) disable iff (sys_rst)
    (!m_fall && ms_free) |=> $stable(ms_slv_q))
    else $error("slave moved without a clock fall");

  a_ms_fall_copy: assert property (
    @(posedge clock) disable iff (sys_rst)
    (m_fall && ms_free) |=> (ms_slv_q == $past(ms_mst_q)))
    else $error("slave did not take master at fall");

  a_ms_fall_out: assert property (
    @(posedge clock) disable iff (sys_rst)
    (m_fall && ms_free) |=> (m_out.q == $past(ms_mst_q)))
    else $error("outputs did not show master at fall");

  a_ms_set_steer: assert property (
    @(posedge clock) disable iff (sys_rst)
    (m_fall && ms_free && $past(ms_free) && mj_s && !mk_s) |=> ms_slv_q)
    else $error("set steering did not give one");

  a_ms_clr_steer: assert property (
    @(posedge clock) disable iff (sys_rst)
    (m_fall && ms_free && $past(ms_free) && !mj_s && mk_s) |=> !ms_slv_q)
    else $error("clear steering did not give zero");

  a_ms_keep_steer: assert property (
    @(posedge clock) disable iff (sys_rst)
    (m_fall && ms_free && $past(ms_free) && !mj_s && !mk_s) |=> $stable(ms_slv_q))
    else $error("idle steering changed the state");

  a_ms_toggle: assert property (
    @(posedge clock) disable iff (sys_rst)
    (m_rise && mj_s && mk_s && ms_free) |=> (ms_mst_q == !ms_slv_q))
    else $error("master did not prepare complement");

  a_ms_toggle_fall: assert property (
    @(posedge clock) disable iff (sys_rst)
    (m_fall && ms_free && $past(ms_free) && mj_s && mk_s) |=> (ms_slv_q != $past(ms_slv_q)))
    else $error("slave did not complement at fall");

  a_ms_out_track: assert property (
    @(posedge clock) disable iff (sys_rst)
    (m_out.q == ms_slv_q) && (m_out.q_n == !ms_slv_q))
    else $error("outputs differ from slave");
endmodule

// [verif/effp_drv.sv]
/*
  effp_drv: far-side logic model that drives both flops.
  assumes: clock is the bench clock; callers run one task at a time.
*/
`timescale 1ns/1ps
module effp_drv
(
  input  wire logic clock,
  output logic      d_clk,
  output logic      d_data,
  output logic      d_set_n,
  output logic      d_clr_n,
  output logic      m_clk,
  output logic      m_jset,
  output logic      m_kclr,
  output logic      m_set_n,
  output logic      m_clr_n
);
  // ==========================================================
  // timing pulses, distributed low-going
  logic tpd_n = 1'b1;
  logic tpm_n = 1'b1;
  assign d_clk = ~tpd_n;
  assign m_clk = ~tpm_n;

  initial
  begin
    {d_data, m_jset, m_kclr} = 3'h0;
    {d_set_n, d_clr_n, m_set_n, m_clr_n} = 4'hf;
  end

  // ==========================================================
  // tasks, all changes land 1 ns after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // steering only moves here, also while a clock pulse is high
  task automatic steer(input logic d, input logic j, input logic k);
    tick(1);
    d_data = d;
    m_jset = j;
    m_kclr = k;
    tick(8);
  endtask

  // slow pulses: the flops see pins through synchronisers
  task automatic clk_lvl(input logic dsel, input logic lvl);
    tick(1);
    if (dsel)
      tpd_n = ~lvl;
    else
      tpm_n = ~lvl;
    tick(10);
  endtask

  task automatic direct(input logic [3:0] v);
    tick(1);
    {d_set_n, d_clr_n, m_set_n, m_clr_n} = v;
    tick(8);
  endtask
endmodule

// [verif/effp_top_tb.sv]
/*
  effp_top_tb: self-checking bench for the flop pair.
  assumes: effp_drv drives every input pin of the design except clock and sys_rst.
*/
`timescale 1ns/1ps
module effp_top_tb;
  import effp_pkg::*;
  // ==========================================================
  // wiring
  logic      clock = 1'b0;
  logic      sys_rst = 1'b1;
  logic      d_clk, d_data, d_set_n, d_clr_n;
  logic      m_clk, m_jset, m_kclr, m_set_n, m_clr_n;
  effp_out_s d_out;
  effp_out_s m_out;
  int        n_mismatch = 0;
  int        checked = 0;

  always #4 clock = ~clock;

  effp_top dut_u (.clock(clock), .sys_rst(sys_rst), .d_clk(d_clk), .d_data(d_data),
    .d_set_n(d_set_n), .d_clr_n(d_clr_n), .d_out(d_out), .m_clk(m_clk),
    .m_jset(m_jset), .m_kclr(m_kclr), .m_set_n(m_set_n), .m_clr_n(m_clr_n),
    .m_out(m_out));
  effp_drv drv_u (.clock(clock), .d_clk(d_clk), .d_data(d_data), .d_set_n(d_set_n),
    .d_clr_n(d_clr_n), .m_clk(m_clk), .m_jset(m_jset), .m_kclr(m_kclr),
    .m_set_n(m_set_n), .m_clr_n(m_clr_n));

  // ==========================================================
  // helpers
  function automatic effp_out_s os(input logic q);
    return '{q: q, q_n: ~q};
  endfunction

  task automatic chk(input string what, input effp_out_s exp, input effp_out_s got);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("FAIL %s expected %b seen %b", what, exp, got);
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic test_capture();
    drv_u.steer(1'b1, 1'b0, 1'b0);
    drv_u.clk_lvl(1'b1, 1'b1);
    chk("d_out one", os(1'b1), d_out);
    drv_u.clk_lvl(1'b1, 1'b0);
    drv_u.steer(1'b0, 1'b0, 1'b0);
    drv_u.clk_lvl(1'b1, 1'b1);
    chk("d_out zero", os(1'b0), d_out);
    drv_u.clk_lvl(1'b1, 1'b0);
    $display("test capture done");
  endtask

  // data moves while the clock is high and must be ignored
  task automatic test_lockout();
    drv_u.steer(1'b1, 1'b0, 1'b0);
    drv_u.clk_lvl(1'b1, 1'b1);
    drv_u.steer(1'b0, 1'b0, 1'b0);
    chk("d_out locked", os(1'b1), d_out);
    drv_u.clk_lvl(1'b1, 1'b0);
    chk("d_out after fall", os(1'b1), d_out);
    $display("test lockout done");
  endtask

  task automatic test_steer();
    logic [11:0] tbl = 12'b10_00_11_11_01_00;
    logic        j;
    logic        k;
    logic        q;
    q = 1'b0;
    for (int i = 5; i >= 0; i--)
    begin
      j = tbl[2*i+1];
      k = tbl[2*i];
      drv_u.steer(1'b0, j, k);
      drv_u.clk_lvl(1'b0, 1'b1);
      chk("m_out clock high", os(q), m_out);
      drv_u.clk_lvl(1'b0, 1'b0);
      q = (j & k) ? ~q : (j | (q & ~k));
      chk("m_out after fall", os(q), m_out);
    end
    $display("test steer done");
  endtask

  task automatic test_direct();
    logic [3:0] pat [5] = '{4'h5, 4'hf, 4'ha, 4'h5, 4'h0};
    logic [0:4] qe = 5'b11010;
    for (int i = 0; i < 5; i++)
    begin
      drv_u.direct(pat[i]);
      chk("d_out direct", os(qe[i]), d_out);
      chk("m_out direct", os(qe[i]), m_out);
    end
    drv_u.direct(4'hf);
    $display("test direct done");
  endtask

  // ==========================================================
  // sequence and verdict
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    repeat (4) @(posedge clock);
    #1;
    chk("d_out reset", os(1'b0), d_out);
    chk("m_out reset", os(1'b0), m_out);
    test_capture();
    test_lockout();
    test_steer();
    test_direct();
    complete_run();
  end

  // a hang counts as a mismatch
  initial
  begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    $display("FAIL watchdog expected finish seen hang");
    complete_run();
  end
endmodule
